// ===== verilog/cbd_pkg.sv
// package: constants, encodings and carriers for the branch/clear/decrement core slice
package cbd_pkg;
    // Notes on behaviour
    // (RULE_01) clear accumulator loads zero, sets null flag
    // (RULE_02) subroutine jump pushes program counter plus one
    // (RULE_03) jump target: literal low, latch bits 4:3 high
    // (RULE_04) subroutine jump: full literal, two cycles, flags kept
    // (RULE_05) absolute branch loads same target, no push
    // (RULE_06) absolute branch: two cycles, flags kept
    // (RULE_07) watchdog kick clears counter and prescaler
    // (RULE_08) watchdog kick sets timeout and powerdown flags
    // (RULE_09) complement register, null flag, selectable destination
    // (RULE_10) decrement register, null flag, selectable destination
    // (RULE_11) decrement-and-skip stores result, flags kept
    // (RULE_12) zero result turns next instruction into idle
    // (RULE_13) decode seven-bit index and one destination bit

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int INSN_PERIOD_NS = 200;
    localparam int CLKS_PER_INSN = INSN_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [1:0] PH_FETCH = 2'h1;
    localparam logic [1:0] PH_EXEC = 2'h3;

    // ------------------------------------------------------------
    // widths and instruction fields
    // ------------------------------------------------------------
    localparam int PC_W = 13;
    localparam int INSN_W = 14;
    localparam int LIT_W = 11;
    localparam int IDX_W = 7;
    localparam int DEST_POS = 7;
    localparam int PHL_W = 5;
    localparam int PHL_PAGE_LO = 3;
    localparam int PHL_PAGE_HI = 4;
    localparam logic [5:0] OPC_COMPLEMENT = 6'h09;
    localparam logic [5:0] OPC_DECREMENT = 6'h03;
    localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;
    localparam logic [6:0] OPC_CLEAR_ACC = 7'h02;
    localparam logic [13:0] OPC_KICK_WDT = 14'h0064;
    localparam logic [2:0] OPC_CALL = 3'h4;
    localparam logic [2:0] OPC_BRANCH = 3'h5;

    // ------------------------------------------------------------
    // register port map and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_ACC = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_PHL = 4'h2;
    localparam logic [3:0] ADDR_PC_LO = 4'h3;
    localparam logic [3:0] ADDR_PC_HI = 4'h4;
    localparam logic [3:0] ADDR_WDT = 4'h5;
    localparam logic [3:0] ADDR_CTRL = 4'h6;
    localparam int ST_NULL_POS = 2;
    localparam int ST_PD_POS = 3;
    localparam int ST_TO_POS = 4;
    localparam int CTRL_RUN_POS = 0;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [4:0] PHL_RESET = 5'h00;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [7:0] CTRL_RESET = 8'h01;
    localparam logic [7:0] WDT_RESET = 8'h00;
    localparam int STACK_DEPTH = 8;
    localparam int WDT_PRESC_W = 7;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic {
        CBD_EXEC = 1'b0,
        CBD_FLUSH = 1'b1
    } cbd_state_t;

    typedef enum logic [2:0] {
        CBD_OP_IDLE,
        CBD_OP_CLEAR_ACC,
        CBD_OP_CALL,
        CBD_OP_BRANCH,
        CBD_OP_KICK,
        CBD_OP_COMPLEMENT,
        CBD_OP_DECREMENT,
        CBD_OP_DEC_SKIP
    } cbd_op_t;

    typedef struct packed {
        cbd_op_t op;
        logic [IDX_W-1:0] reg_idx;
        logic dest_reg;
        logic [LIT_W-1:0] literal;
    } cbd_decoded_t;

    typedef struct packed {
        logic timeout_flag;
        logic powerdown_flag;
        logic null_flag;
    } cbd_status_t;

    localparam cbd_status_t STATUS_RESET = '{timeout_flag: 1'b1, powerdown_flag: 1'b1, null_flag: 1'b0};
endpackage

// ===== verilog/cbd_return_stack.sv
// hardware return stack, push only from this slice, wraps on overflow
`timescale 1ns/1ps
module cbd_return_stack #(
    parameter int DEPTH = cbd_pkg::STACK_DEPTH
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // push side
    input wire logic push,
    input wire logic [cbd_pkg::PC_W-1:0] push_addr,
    // top of stack
    output logic [cbd_pkg::PC_W-1:0] stack_top_entry
);
    import cbd_pkg::*;

    logic [PC_W-1:0] slots [DEPTH];
    logic [$clog2(DEPTH)-1:0] ptr;
    logic [$clog2(DEPTH)-1:0] next_ptr;

    always_comb begin
        next_ptr = push ? ptr + 1'b1 : ptr;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ptr <= '0;
        end else begin
            ptr <= next_ptr;
        end
    end

    // slots clear on reset so the top never shows an unknown
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                slots[i] <= PC_RESET;
            end
        end else if (push) begin
            slots[next_ptr] <= push_addr;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stack_top_entry <= PC_RESET;
        end else begin
            stack_top_entry <= push ? push_addr : slots[ptr];
        end
    end
endmodule

// ===== verilog/cbd_watchdog.sv
// watchdog counter with prescaler; prescaler advanced once per instruction cycle, counter once per 128
`timescale 1ns/1ps
module cbd_watchdog #(
    parameter int PRESC_W = cbd_pkg::WDT_PRESC_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control
    input wire logic tick,
    input wire logic kick,
    // state
    output logic [7:0] watchdog_counter,
    output logic timeout
);
    import cbd_pkg::*;

    logic [PRESC_W-1:0] presc;
    logic [PRESC_W-1:0] next_presc;
    logic [7:0] next_count;
    logic next_timeout;

    always_comb begin
        next_presc = presc;
        next_count = watchdog_counter;
        next_timeout = 1'b0;
        if (kick) begin
            next_presc = '0; // RULE_07
            next_count = WDT_RESET; // RULE_07
        end else if (tick) begin
            next_presc = presc + 1'b1;
            if (&presc) begin
                next_count = watchdog_counter + 8'h01;
                next_timeout = &watchdog_counter;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            presc <= '0;
            watchdog_counter <= WDT_RESET;
            timeout <= 1'b0;
        end else begin
            presc <= next_presc;
            watchdog_counter <= next_count;
            timeout <= next_timeout;
        end
    end
endmodule

// ===== verilog/cbd_core.sv
// core slice: fetch/execute of clear, branch, call, watchdog kick, complement and decrement
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
module cbd_core (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // program memory
    output logic [cbd_pkg::PC_W-1:0] prog_addr,
    input wire logic [cbd_pkg::INSN_W-1:0] instr,
    // data file
    output logic [cbd_pkg::IDX_W-1:0] fr_addr,
    input wire logic [7:0] fr_rdata,
    output logic [7:0] fr_wdata,
    output logic fr_we,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // observation
    output logic [cbd_pkg::PC_W-1:0] stack_top_entry,
    output logic insn_strobe,
    output logic wdt_timeout
);
    import cbd_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic is_null(input logic [7:0] v);
        return v == 8'h00;
    endfunction

    function automatic cbd_decoded_t decode(input logic [INSN_W-1:0] w);
        cbd_decoded_t d;
        d.reg_idx = w[IDX_W-1:0]; // RULE_13
        d.dest_reg = w[DEST_POS]; // RULE_13
        d.literal = w[LIT_W-1:0];
        d.op = CBD_OP_IDLE;
        if (w[13:11] == OPC_CALL) begin
            d.op = CBD_OP_CALL;
        end else if (w[13:11] == OPC_BRANCH) begin
            d.op = CBD_OP_BRANCH;
        end else if (w == OPC_KICK_WDT) begin
            d.op = CBD_OP_KICK;
        end else if (w[13:7] == OPC_CLEAR_ACC) begin
            d.op = CBD_OP_CLEAR_ACC;
        end else if (w[13:8] == OPC_COMPLEMENT) begin
            d.op = CBD_OP_COMPLEMENT;
        end else if (w[13:8] == OPC_DECREMENT) begin
            d.op = CBD_OP_DECREMENT;
        end else if (w[13:8] == OPC_DEC_SKIP) begin
            d.op = CBD_OP_DEC_SKIP;
        end
        return d;
    endfunction

    // ------------------------------------------------------------
    // instruction-cycle divider
    // ------------------------------------------------------------
    logic [1:0] phase;
    logic [1:0] next_phase;
    logic fetch_en;
    logic exec_en;

    // phase 1 latches the word, phase 3 executes it
    always_comb begin
        next_phase = (phase == 2'(CLKS_PER_INSN - 1)) ? 2'h0 : phase + 2'h1;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase <= 2'h0;
        end else begin
            phase <= next_phase;
        end
    end

    // ------------------------------------------------------------
    // architectural state
    // ------------------------------------------------------------
    logic [INSN_W-1:0] ir;
    logic [7:0] accumulator;
    cbd_status_t status;
    logic [PHL_W-1:0] page_high_latch;
    logic [PC_W-1:0] program_counter;
    logic [7:0] ctrl;
    cbd_state_t state;
    logic write_pending;
    logic [7:0] watchdog_count;

    logic [INSN_W-1:0] next_ir;
    logic [7:0] next_accumulator;
    cbd_status_t next_status;
    logic [PHL_W-1:0] next_page_high_latch;
    logic [PC_W-1:0] next_program_counter;
    logic [7:0] next_ctrl;
    cbd_state_t next_state;
    logic next_write_pending;
    logic [7:0] next_fr_wdata;
    logic [7:0] next_reg_rdata;

    cbd_decoded_t dec;
    logic [7:0] alu_result;
    logic [PC_W-1:0] jump_target;
    logic [PC_W-1:0] return_addr;
    logic push;
    logic kick;
    logic run;
    logic slot_live;

    assign run = ctrl[CTRL_RUN_POS];
    assign fetch_en = run && (phase == PH_FETCH);
    assign exec_en = run && (phase == PH_EXEC);
    assign dec = decode(ir);
    // RULE_03 RULE_05
    assign jump_target = {page_high_latch[PHL_PAGE_HI:PHL_PAGE_LO], dec.literal};
    assign return_addr = program_counter + 13'h0001; // RULE_02
    // a flushed slot must neither push nor kick
    assign slot_live = exec_en && (state == CBD_EXEC);
    assign push = slot_live && (dec.op == CBD_OP_CALL); // RULE_02
    assign kick = slot_live && (dec.op == CBD_OP_KICK); // RULE_07

    always_comb begin
        unique case (dec.op)
            CBD_OP_COMPLEMENT: begin
                alu_result = ~fr_rdata; // RULE_09
            end
            CBD_OP_DECREMENT, CBD_OP_DEC_SKIP: begin
                alu_result = fr_rdata - 8'h01; // RULE_10 RULE_11
            end
            default: alu_result = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // execution
    // ------------------------------------------------------------
    always_comb begin
        next_ir = fetch_en ? instr : ir;
        next_accumulator = accumulator;
        next_status = status;
        next_page_high_latch = page_high_latch;
        next_program_counter = program_counter;
        next_ctrl = ctrl;
        next_state = state;
        next_write_pending = 1'b0;
        next_fr_wdata = fr_wdata;

        // software writes first; execution results override in the same cycle
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_ACC: next_accumulator = reg_wdata;
                ADDR_STATUS: next_status = '{timeout_flag: reg_wdata[ST_TO_POS],
                                             powerdown_flag: reg_wdata[ST_PD_POS],
                                             null_flag: reg_wdata[ST_NULL_POS]};
                ADDR_PHL: next_page_high_latch = reg_wdata[PHL_W-1:0];
                ADDR_CTRL: next_ctrl = {7'h00, reg_wdata[CTRL_RUN_POS]};
                default: ;
            endcase
        end

        if (wdt_timeout) begin
            next_status.timeout_flag = 1'b0;
        end

        if (exec_en) begin
            next_program_counter = program_counter + 13'h0001;
            next_state = CBD_EXEC;
            if (state == CBD_EXEC) begin
                unique case (dec.op)
                    CBD_OP_CLEAR_ACC: begin
                        next_accumulator = ACC_RESET; // RULE_01
                        next_status.null_flag = 1'b1; // RULE_01
                    end
                    CBD_OP_CALL, CBD_OP_BRANCH: begin
                        // flags untouched, second cycle is a flushed fetch
                        next_program_counter = jump_target; // RULE_03 RULE_04 RULE_05 RULE_06
                        next_state = CBD_FLUSH; // RULE_04 RULE_06
                    end
                    CBD_OP_KICK: begin
                        next_status.timeout_flag = 1'b1; // RULE_08
                        next_status.powerdown_flag = 1'b1; // RULE_08
                    end
                    CBD_OP_COMPLEMENT, CBD_OP_DECREMENT: begin
                        next_status.null_flag = is_null(alu_result); // RULE_09 RULE_10
                        if (dec.dest_reg) begin
                            next_fr_wdata = alu_result; // RULE_09 RULE_10
                            next_write_pending = 1'b1;
                        end else begin
                            next_accumulator = alu_result; // RULE_09 RULE_10
                        end
                    end
                    CBD_OP_DEC_SKIP: begin
                        if (dec.dest_reg) begin
                            next_fr_wdata = alu_result; // RULE_11
                            next_write_pending = 1'b1;
                        end else begin
                            next_accumulator = alu_result; // RULE_11
                        end
                        if (is_null(alu_result)) begin
                            next_state = CBD_FLUSH; // RULE_12
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ir <= '0;
            accumulator <= ACC_RESET;
            status <= STATUS_RESET;
            page_high_latch <= PHL_RESET;
            program_counter <= PC_RESET;
            ctrl <= CTRL_RESET;
            state <= CBD_EXEC;
            write_pending <= 1'b0;
            fr_wdata <= 8'h00;
        end else begin
            ir <= next_ir;
            accumulator <= next_accumulator;
            status <= next_status;
            page_high_latch <= next_page_high_latch;
            program_counter <= next_program_counter;
            ctrl <= next_ctrl;
            state <= next_state;
            write_pending <= next_write_pending;
            fr_wdata <= next_fr_wdata;
        end
    end

    // data-file write lands one clock after execute, while the index still holds
    assign fr_we = write_pending;
    assign fr_addr = dec.reg_idx;
    assign prog_addr = program_counter;
    assign insn_strobe = exec_en;

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_comb begin
        next_reg_rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_ACC: next_reg_rdata = accumulator;
                ADDR_STATUS: begin
                    next_reg_rdata[ST_TO_POS] = status.timeout_flag;
                    next_reg_rdata[ST_PD_POS] = status.powerdown_flag;
                    next_reg_rdata[ST_NULL_POS] = status.null_flag;
                end
                ADDR_PHL: begin
                    next_reg_rdata = {3'h0, page_high_latch};
                end
                ADDR_PC_LO: begin
                    next_reg_rdata = program_counter[7:0];
                end
                ADDR_PC_HI: begin
                    next_reg_rdata = {3'h0, program_counter[PC_W-1:8]};
                end
                ADDR_WDT: begin
                    next_reg_rdata = watchdog_count;
                end
                ADDR_CTRL: next_reg_rdata = ctrl;
                default: next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    cbd_return_stack #(
        .DEPTH(STACK_DEPTH)
    ) u_stack (
        .ref_clk(ref_clk),
        .rst(rst),
        .push(push),
        .push_addr(return_addr),
        .stack_top_entry(stack_top_entry)
    );

    cbd_watchdog #(
        .PRESC_W(WDT_PRESC_W)
    ) u_wdt (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick(exec_en),
        .kick(kick),
        .watchdog_counter(watchdog_count),
        .timeout(wdt_timeout)
    );
endmodule

// ===== bench/cbd_core_asserts.sv
// checker: port-level properties of the core slice
`timescale 1ns/1ps
module cbd_core_asserts (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // program memory
    input wire logic [cbd_pkg::PC_W-1:0] prog_addr,
    input wire logic [cbd_pkg::INSN_W-1:0] instr,
    // data file
    input wire logic [cbd_pkg::IDX_W-1:0] fr_addr,
    input wire logic [7:0] fr_rdata,
    input wire logic [7:0] fr_wdata,
    input wire logic fr_we,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // observation
    input wire logic [cbd_pkg::PC_W-1:0] stack_top_entry,
    input wire logic insn_strobe,
    input wire logic wdt_timeout
);
    import cbd_pkg::*;
    // ----------------------------------------
    // helper: instruction seen at fetch, flush tracking
    // ----------------------------------------
    logic [13:0] ir1;
    logic [13:0] ir2;
    logic skip_nxt;
    logic [7:0] wres;
    logic is_call;
    logic is_br;
    logic is_reg;
    logic live;
    assign is_call = ir2[13:11] == OPC_CALL;
    assign is_br = ir2[13:11] == OPC_BRANCH;
    assign is_reg = ir2[13:8] == OPC_COMPLEMENT || ir2[13:8] == OPC_DECREMENT || ir2[13:8] == OPC_DEC_SKIP;
    assign live = insn_strobe && !skip_nxt;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ir1 <= '0;
            ir2 <= '0;
            skip_nxt <= 1'b0;
            wres <= '0;
        end else begin
            ir1 <= instr;
            ir2 <= ir1;
            if (insn_strobe) begin
                skip_nxt <= live && (is_call || is_br || (ir2[13:8] == OPC_DEC_SKIP && fr_rdata == 8'h01));
                wres <= (ir2[13:8] == OPC_COMPLEMENT) ? ~fr_rdata : fr_rdata - 8'h01;
            end
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_call_push;
        live && is_call |=> stack_top_entry == $past(prog_addr) + 13'h0001;
    endproperty
    a_call_push: assert property (p_call_push) else $error("return address not pushed");
    property p_jump_low;
        live && (is_call || is_br) |=> prog_addr[10:0] == $past(ir2[10:0]);
    endproperty
    a_jump_low: assert property (p_jump_low) else $error("jump literal not loaded");
    property p_branch_no_push;
        live && is_br |=> $stable(stack_top_entry);
    endproperty
    a_branch_no_push: assert property (p_branch_no_push) else $error("branch touched stack");
    property p_flush_idle;
        insn_strobe && skip_nxt |=> $stable(stack_top_entry) && !fr_we ##1 !fr_we;
    endproperty
    a_flush_idle: assert property (p_flush_idle) else $error("discarded slot had effects");
    property p_acc_dest;
        live && is_reg && !ir2[DEST_POS] |=> !fr_we ##1 !fr_we;
    endproperty
    a_acc_dest: assert property (p_acc_dest) else $error("file written for acc destination");
    property p_file_dest;
        live && is_reg && ir2[DEST_POS] |-> ##[1:2] fr_we;
    endproperty
    a_file_dest: assert property (p_file_dest) else $error("file not written back");
    property p_wdata;
        fr_we |-> fr_wdata == wres;
    endproperty
    a_wdata: assert property (p_wdata) else $error("wrong write-back value");
    property p_slot_len;
        insn_strobe |=> !insn_strobe [*3];
    endproperty
    a_slot_len: assert property (p_slot_len) else $error("instruction slot too short");
    property p_kick_quiet;
        live && ir2 == OPC_KICK_WDT |=> !wdt_timeout [*8];
    endproperty
    a_kick_quiet: assert property (p_kick_quiet) else $error("timeout right after kick");
    c_call: cover property (live && is_call);
    c_branch: cover property (live && is_br);
    c_flush: cover property (insn_strobe && skip_nxt);
    c_write: cover property (fr_we);
endmodule

// ===== bench/cbd_testbench.sv
// testbench: table-driven instruction checks, register port and watchdog kick
`timescale 1ns/1ps
module testbench;
    import cbd_pkg::*;
    typedef struct {
        logic [13:0] op;
        logic [13:0] nxt;
        logic [7:0] fv;
        logic [4:0] phl;
        logic [7:0] st;
        logic [7:0] acc;
        logic [7:0] fil;
        logic [7:0] est;
        logic [12:0] pc;
        logic [12:0] stk;
    } cbd_row_t;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [12:0] prog_addr;
    logic [13:0] instr = '0;
    logic [6:0] fr_addr;
    logic [7:0] fr_rdata = '0;
    logic [7:0] fr_wdata;
    logic fr_we;
    logic [3:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [12:0] stack_top_entry;
    logic insn_strobe;
    logic wdt_timeout;
    logic [13:0] rom [0:8191];
    logic [7:0] dfile [0:127];
    logic [7:0] v;
    logic [7:0] h;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    // op, next word, file value, page latch, status preset, acc, file, status, pc, stack
    cbd_row_t rows [12] = '{
        '{14'h0100, 14'h0000, 8'h33, 5'h00, 8'h00, 8'h00, 8'h33, 8'h04, 13'h0003, 13'h0000},
        '{14'h0905, 14'h0000, 8'h0f, 5'h00, 8'h04, 8'hf0, 8'h0f, 8'h00, 13'h0003, 13'h0000},
        '{14'h0985, 14'h0000, 8'hff, 5'h00, 8'h00, 8'h5a, 8'h00, 8'h04, 13'h0003, 13'h0000},
        '{14'h0305, 14'h0000, 8'h01, 5'h00, 8'h00, 8'h00, 8'h01, 8'h04, 13'h0003, 13'h0000},
        '{14'h0385, 14'h0000, 8'h00, 5'h00, 8'h04, 8'h5a, 8'hff, 8'h00, 13'h0003, 13'h0000},
        '{14'h0b85, 14'h0100, 8'h01, 5'h00, 8'h00, 8'h5a, 8'h00, 8'h00, 13'h0003, 13'h0000},
        '{14'h0b85, 14'h0100, 8'h05, 5'h00, 8'h00, 8'h00, 8'h04, 8'h04, 13'h0003, 13'h0000},
        '{14'h0b05, 14'h0000, 8'h03, 5'h00, 8'h10, 8'h02, 8'h03, 8'h10, 13'h0003, 13'h0000},
        '{14'h27fe, 14'h0100, 8'h00, 5'h18, 8'h04, 8'h5a, 8'h00, 8'h04, 13'h1fff, 13'h0002},
        '{14'h2000, 14'h0100, 8'h00, 5'h07, 8'h00, 8'h5a, 8'h00, 8'h00, 13'h0001, 13'h0002},
        '{14'h2923, 14'h0100, 8'h00, 5'h0b, 8'h10, 8'h5a, 8'h00, 8'h10, 13'h0924, 13'h0000},
        '{14'h0064, 14'h0000, 8'h00, 5'h00, 8'h00, 8'h5a, 8'h00, 8'h18, 13'h0003, 13'h0000}
    };

    cbd_core uut (
        .ref_clk(ref_clk), .rst(rst), .prog_addr(prog_addr), .instr(instr),
        .fr_addr(fr_addr), .fr_rdata(fr_rdata), .fr_wdata(fr_wdata), .fr_we(fr_we),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .stack_top_entry(stack_top_entry), .insn_strobe(insn_strobe),
        .wdt_timeout(wdt_timeout)
    );

    always #25 ref_clk = ~ref_clk;

    // ----------------------------------------
    // program memory and data file
    // ----------------------------------------
    always @(posedge ref_clk) begin
        instr <= rom[prog_addr];
        if (fr_we) begin
            dfile[fr_addr] <= fr_wdata;
        end
        fr_rdata <= dfile[fr_addr];
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge ref_clk);
    endtask

    task automatic reset_dut(input logic [13:0] fill);
        for (int a = 0; a < 8192; a++) begin
            rom[a] = fill;
        end
        rst <= 1'b1;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        @(posedge ref_clk);
        // ----------------------------------------
        // table rows: instruction at address 1, stopped after its following slot
        // ----------------------------------------
        foreach (rows[i]) begin
            reset_dut(rows[i].nxt);
            rom[0] = 14'h0000;
            rom[1] = rows[i].op;
            dfile[5] = rows[i].fv;
            wr(ADDR_PHL, {3'h0, rows[i].phl});
            wr(ADDR_STATUS, rows[i].st);
            wr(ADDR_ACC, 8'h5a);
            repeat (6) @(posedge ref_clk);
            wr(ADDR_CTRL, 8'h00);
            rd(ADDR_ACC, v);
            chk(16'(v), 16'(rows[i].acc));
            rd(ADDR_STATUS, v);
            chk(16'(v & 8'h1c), 16'(rows[i].est));
            rd(ADDR_PC_LO, v);
            rd(ADDR_PC_HI, h);
            chk(16'({h[4:0], v}), 16'(rows[i].pc));
            chk(16'(stack_top_entry), 16'(rows[i].stk));
            chk(16'(dfile[5]), 16'(rows[i].fil));
            $display("row %0d finished", i);
        end
        // ----------------------------------------
        // reset values, refused writes, watchdog kick
        // ----------------------------------------
        reset_dut(14'h0000);
        rom[160] = OPC_KICK_WDT;
        rd(ADDR_ACC, v);
        chk(16'(v), 16'(ACC_RESET));
        rd(ADDR_STATUS, v);
        chk(16'(v & 8'h1c), 16'({STATUS_RESET, 2'b00}));
        rd(ADDR_PHL, v);
        chk(16'(v), 16'(PHL_RESET));
        rd(ADDR_CTRL, v);
        chk(16'(v), 16'(CTRL_RESET));
        rd(ADDR_WDT, v);
        chk(16'(v), 16'(WDT_RESET));
        wr(4'hf, 8'hff);
        rd(4'hf, v);
        chk(16'(v), 16'h0000);
        wr(ADDR_WDT, 8'h77);
        rd(ADDR_WDT, v);
        chk(16'(v), 16'h0000);
        repeat (540) @(posedge ref_clk);
        rd(ADDR_WDT, v);
        chk(16'(v), 16'h0001);
        repeat (520) @(posedge ref_clk);
        rd(ADDR_WDT, v);
        chk(16'(v), 16'h0000);
        $display("register port and watchdog test finished");
        stop_test();
    end
endmodule

bind cbd_core cbd_core_asserts u_chk (
    .ref_clk(ref_clk), .rst(rst), .prog_addr(prog_addr), .instr(instr),
    .fr_addr(fr_addr), .fr_rdata(fr_rdata), .fr_wdata(fr_wdata), .fr_we(fr_we),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .stack_top_entry(stack_top_entry), .insn_strobe(insn_strobe),
    .wdt_timeout(wdt_timeout)
);
